// ---- hdl/rpseq_board.sv ----
/*
 * board end: power-good and reset sequencing, management interrupt
 * and configuration straps towards the processor.
 * assumes supply and clock status inputs are asynchronous.
 */
`timescale 1ns/1ps
`include "rpseq_params.svh"

module rpseq_board #(
    parameter int POR_HOLD_CYC = `RPSEQ_POR_HOLD_CYC,
    parameter int RST_MAX_CYC  = `RPSEQ_RST_MAX_CYC,
    parameter int STABLE_CYC   = `RPSEQ_STABLE_CYC
) (
    // link
    rpseq_if.board                   lnk,
    // user side
    input  wire logic                suppliesOk,
    input  wire logic                clocksOk,
    input  wire logic                warmResetReq,
    input  wire logic                mgmtIntReq,
    input  wire logic                scanActive,
    input  wire logic [`RPSEQ_CFG_W-1:0] strapValue,
    output logic                     cpuRunning,
    output logic                     mgmtAckSeen
);

    // ************************************
    // synchronisers
    // ************************************
    logic [1:0] supSync_q;
    logic [1:0] clkSync_q;
    logic       stable;

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            supSync_q <= 2'h0;
            clkSync_q <= 2'h0;
        end else begin
            supSync_q <= {supSync_q[0], suppliesOk};
            clkSync_q <= {clkSync_q[0], clocksOk};
        end
    end

    assign stable = supSync_q[1] && clkSync_q[1];

    // ************************************
    // sequence
    // ************************************
    rpseq_pkg::rpseq_board_st_t state_q;
    logic [31:0]                cnt_q;

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            state_q <= rpseq_pkg::BRD_OFF;
            cnt_q   <= 32'h0;
        end else if (!stable && !scanActive) begin
            state_q <= rpseq_pkg::BRD_OFF;
            cnt_q   <= 32'h0;
        end else begin
            unique case (state_q)
                rpseq_pkg::BRD_OFF: begin
                    state_q <= rpseq_pkg::BRD_WAIT_STABLE;
                    cnt_q   <= 32'h0;
                end
                rpseq_pkg::BRD_WAIT_STABLE: begin
                    if (cnt_q >= 32'(STABLE_CYC - 1)) begin
                        state_q <= rpseq_pkg::BRD_POR_HOLD;
                        cnt_q   <= 32'h0;
                    end else
                        cnt_q <= cnt_q + 32'h1;
                end
                rpseq_pkg::BRD_POR_HOLD: begin
                    if (cnt_q >= 32'(POR_HOLD_CYC - 1)) begin
                        state_q <= rpseq_pkg::BRD_RUN;
                        cnt_q   <= 32'h0;
                    end else
                        cnt_q <= cnt_q + 32'h1;
                end
                rpseq_pkg::BRD_RUN: begin
                    if (warmResetReq && !scanActive) begin
                        state_q <= rpseq_pkg::BRD_WARM_HOLD;
                        cnt_q   <= 32'h0;
                    end
                end
                rpseq_pkg::BRD_WARM_HOLD: begin
                    if (cnt_q >= 32'(POR_HOLD_CYC - 1) || cnt_q >= 32'(RST_MAX_CYC - 1)) begin
                        state_q <= rpseq_pkg::BRD_RUN;
                        cnt_q   <= 32'h0;
                    end else
                        cnt_q <= cnt_q + 32'h1;
                end
            endcase
        end
    end

    // ************************************
    // link outputs
    // ************************************
    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            lnk.powerGood         <= 1'h0;
            lnk.resetReqN         <= 1'h0;
            lnk.sysMgmtInterruptN <= 1'h1;
            lnk.cfgStraps         <= `RPSEQ_CFG_DEFAULT;
            cpuRunning            <= 1'h0;
            mgmtAckSeen           <= 1'h0;
        end else begin
            lnk.powerGood <= scanActive && lnk.powerGood ? 1'h1 :
                             state_q == rpseq_pkg::BRD_POR_HOLD ||
                             state_q == rpseq_pkg::BRD_RUN ||
                             state_q == rpseq_pkg::BRD_WARM_HOLD;
            lnk.resetReqN         <= state_q == rpseq_pkg::BRD_RUN;
            lnk.sysMgmtInterruptN <= !mgmtIntReq;
            lnk.cfgStraps         <= strapValue;
            cpuRunning            <= state_q == rpseq_pkg::BRD_RUN;
            mgmtAckSeen           <= lnk.mgmtAck;
        end
    end

endmodule : rpseq_board

// ---- hdl/rpseq_cpu.sv ----
/*
 * processor end: reset, cache invalidate, strap capture, output float
 * and management interrupt entry.
 * assumes link inputs come from another chip and are synchronised here.
 */
`timescale 1ns/1ps
`include "rpseq_params.svh"

module rpseq_cpu #(
    parameter int LINES = `RPSEQ_CACHE_LINES,
    parameter int BUSW  = `RPSEQ_BUS_W
) (
    // link
    rpseq_if.cpu                     lnk,
    // user side
    input  wire logic [BUSW-1:0]     execData,
    input  wire logic                execDataValid,
    output logic [`RPSEQ_CFG_W-1:0]  cfgCaptured,
    output logic                     inMgmtMode,
    output logic                     outputsFloated,
    output logic                     cacheValidAny,
    output logic [BUSW-1:0]          savedState
);

    // ************************************
    // synchronisers
    // ************************************
    logic [1:0] pgSync_q;
    logic [1:0] rstSync_q;
    logic [1:0] smiSync_q;
    logic       pg;
    logic       rstAct;
    logic       smiAct;
    logic       rstAct_q;

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            pgSync_q  <= 2'h0;
            rstSync_q <= 2'h0;
            smiSync_q <= 2'h3;
            rstAct_q  <= 1'h1;
        end else begin
            pgSync_q  <= {pgSync_q[0], lnk.powerGood};
            rstSync_q <= {rstSync_q[0], lnk.resetReqN};
            smiSync_q <= {smiSync_q[0], lnk.sysMgmtInterruptN};
            rstAct_q  <= rstAct;
        end
    end

    assign pg     = pgSync_q[1];
    assign rstAct = !rstSync_q[1] || !pg;
    assign smiAct = !smiSync_q[1];

    logic releaseEdge;
    assign releaseEdge = rstAct_q && !rstAct;

    // ************************************
    // sequence
    // ************************************
    rpseq_pkg::rpseq_cpu_st_t state_q;
    logic                     smiSeen_q;

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            state_q <= rpseq_pkg::CPU_IDLE;
        end else if (rstAct) begin
            state_q <= rpseq_pkg::CPU_RESET;
        end else begin
            unique case (state_q)
                rpseq_pkg::CPU_IDLE,
                rpseq_pkg::CPU_RESET: begin
                    if (smiAct)
                        state_q <= rpseq_pkg::CPU_FLOAT;
                    else
                        state_q <= rpseq_pkg::CPU_RUN;
                end
                rpseq_pkg::CPU_FLOAT: begin
                    state_q <= rpseq_pkg::CPU_FLOAT;
                end
                rpseq_pkg::CPU_RUN: begin
                    if (smiAct && !smiSeen_q)
                        state_q <= rpseq_pkg::CPU_MGMT_SAVE;
                end
                rpseq_pkg::CPU_MGMT_SAVE: begin
                    state_q <= rpseq_pkg::CPU_MGMT_ACK;
                end
                rpseq_pkg::CPU_MGMT_ACK: begin
                    state_q <= rpseq_pkg::CPU_MGMT_RUN;
                end
                rpseq_pkg::CPU_MGMT_RUN: begin
                    state_q <= rpseq_pkg::CPU_MGMT_RUN;
                end
            endcase
        end
    end

    // one acceptance per falling interrupt level
    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn)
            smiSeen_q <= 1'h0;
        else if (rstAct || !smiAct)
            smiSeen_q <= 1'h0;
        else if (state_q == rpseq_pkg::CPU_RUN)
            smiSeen_q <= 1'h1;
    end

    // ************************************
    // strap capture
    // ************************************
    logic [`RPSEQ_CFG_W-1:0] strapSync0_q;
    logic [`RPSEQ_CFG_W-1:0] strapSync1_q;

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            strapSync0_q <= `RPSEQ_CFG_DEFAULT;
            strapSync1_q <= `RPSEQ_CFG_DEFAULT;
        end else begin
            strapSync0_q <= lnk.cfgStraps;
            strapSync1_q <= strapSync0_q;
        end
    end

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn)
            cfgCaptured <= `RPSEQ_CFG_DEFAULT;
        else if (releaseEdge)
            cfgCaptured <= strapSync1_q;
    end

    // ************************************
    // cache valid bits and saved state
    // ************************************
    logic [LINES-1:0]              cacheValid_q;
    logic [$clog2(LINES)-1:0]      fillPtr_q;

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            cacheValid_q <= '0;
            fillPtr_q    <= '0;
        end else if (rstAct) begin
            cacheValid_q <= '0;
            fillPtr_q    <= '0;
        end else if (execDataValid && state_q == rpseq_pkg::CPU_RUN) begin
            cacheValid_q[fillPtr_q] <= 1'h1;
            fillPtr_q               <= fillPtr_q + 1'b1;
        end
    end

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn)
            cacheValidAny <= 1'h0;
        else
            cacheValidAny <= |cacheValid_q;
    end

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn)
            savedState <= '0;
        else if (rstAct)
            savedState <= '0;
        else if (state_q == rpseq_pkg::CPU_MGMT_SAVE)
            savedState <= execData;
    end

    // ************************************
    // bus outputs
    // ************************************
    // interrupt held at release: float on the release cycle too
    logic floatEntry;
    assign floatEntry = smiAct && (state_q == rpseq_pkg::CPU_IDLE || state_q == rpseq_pkg::CPU_RESET);

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            lnk.busOut   <= '0;
            lnk.busOutEn <= 1'h0;
            lnk.mgmtAck  <= 1'h0;
        end else if (rstAct || floatEntry || state_q == rpseq_pkg::CPU_FLOAT) begin
            lnk.busOut   <= '0;
            lnk.busOutEn <= 1'h0;
            lnk.mgmtAck  <= 1'h0;
        end else begin
            lnk.busOut   <= execData;
            lnk.busOutEn <= (state_q == rpseq_pkg::CPU_RUN && execDataValid) ||
                            state_q == rpseq_pkg::CPU_MGMT_ACK;
            lnk.mgmtAck  <= state_q == rpseq_pkg::CPU_MGMT_ACK;
        end
    end

    always_ff @(posedge lnk.clock or negedge lnk.resetn) begin
        if (!lnk.resetn) begin
            inMgmtMode     <= 1'h0;
            outputsFloated <= 1'h1;
        end else begin
            inMgmtMode     <= !rstAct && (state_q == rpseq_pkg::CPU_MGMT_SAVE ||
                              state_q == rpseq_pkg::CPU_MGMT_ACK ||
                              state_q == rpseq_pkg::CPU_MGMT_RUN);
            outputsFloated <= rstAct || floatEntry || state_q == rpseq_pkg::CPU_FLOAT;
        end
    end

endmodule : rpseq_cpu

// ---- hdl/rpseq_if.sv ----
/*
 * link between board reset and power control and the processor.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`include "rpseq_params.svh"

interface rpseq_if (
    input wire logic clock,
    input wire logic resetn
);
    logic                     powerGood;
    logic                     resetReqN;
    logic                     sysMgmtInterruptN;
    logic [`RPSEQ_CFG_W-1:0]  cfgStraps;
    logic [`RPSEQ_BUS_W-1:0]  busOut;
    logic                     busOutEn;
    logic                     mgmtAck;

    modport board (
        input  clock, resetn, busOut, busOutEn, mgmtAck,
        output powerGood, resetReqN, sysMgmtInterruptN, cfgStraps
    );

    modport cpu (
        input  clock, resetn, powerGood, resetReqN, sysMgmtInterruptN, cfgStraps,
        output busOut, busOutEn, mgmtAck
    );
endinterface : rpseq_if

// ---- hdl/rpseq_params.svh ----
/*
 * constants for the reset and power-good sequencer pair: timing counts,
 * configuration width and the power-on strap default.
 * assumes a 125 MHz clock; included by bare name.
 */
`ifndef RPSEQ_PARAMS_SVH
`define RPSEQ_PARAMS_SVH

`define RPSEQ_CLK_MHZ         125
`define RPSEQ_POR_HOLD_US     1000
`define RPSEQ_POR_HOLD_CYC    (`RPSEQ_POR_HOLD_US * `RPSEQ_CLK_MHZ)
`define RPSEQ_RST_MAX_US      10000
`define RPSEQ_RST_MAX_CYC     (`RPSEQ_RST_MAX_US * `RPSEQ_CLK_MHZ)
`define RPSEQ_RELEASE_CLKS    2
`define RPSEQ_CFG_W           8
`define RPSEQ_CFG_DEFAULT     8'h00
`define RPSEQ_STABLE_CYC      16
`define RPSEQ_CACHE_LINES     16
`define RPSEQ_BUS_W           8

`endif

// ---- hdl/rpseq_pkg.sv ----
/*
 * types shared by the sequencer ends.
 * assumes rpseq_params.svh is compiled alongside.
 */
package rpseq_pkg;

    // board side sequence
    typedef enum logic [2:0] {
        BRD_OFF,
        BRD_WAIT_STABLE,
        BRD_POR_HOLD,
        BRD_RUN,
        BRD_WARM_HOLD
    } rpseq_board_st_t;

    // processor side sequence
    typedef enum logic [2:0] {
        CPU_IDLE,
        CPU_RESET,
        CPU_FLOAT,
        CPU_RUN,
        CPU_MGMT_SAVE,
        CPU_MGMT_ACK,
        CPU_MGMT_RUN
    } rpseq_cpu_st_t;

endpackage : rpseq_pkg

// ---- testbench/rpseq_sva.sv ----
/* link checker for the sequencer pair.
 * assumes instantiation beside the link interface, one clock. */
`timescale 1ns/1ps
module rpseq_sva #(
    parameter int POR_HOLD_CYC = 20,
    parameter int RST_MAX_CYC  = 200
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // link
    input wire logic powerGood,
    input wire logic resetReqN,
    input wire logic sysMgmtInterruptN,
    input wire logic busOutEn,
    input wire logic mgmtAck
);
    // ****
    // reset hold counter
    // ****
    logic [31:0] lowCnt_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lowCnt_q <= 32'h0;
        end else if (resetReqN || !powerGood) begin
            lowCnt_q <= 32'h0;
        end else begin
            lowCnt_q <= lowCnt_q + 32'h1;
        end
    end
    // ****
    // properties
    // ****
    por_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        $rose(resetReqN) && powerGood |-> lowCnt_q >= 32'(POR_HOLD_CYC)) else $error("reset released early");
    reset_max_a: assert property (@(posedge clock) disable iff (!resetn)
        lowCnt_q <= 32'(RST_MAX_CYC)) else $error("reset held too long");
    bus_release_a: assert property (@(posedge clock) disable iff (!resetn)
        !resetReqN [*5] |-> !busOutEn) else $error("bus not released in reset");
    pg_clean_a: assert property (@(posedge clock) disable iff (!resetn)
        $rose(powerGood) |=> powerGood [*8]) else $error("power good glitch");
    pg_gate_a: assert property (@(posedge clock) disable iff (!resetn)
        !powerGood [*3] |-> !resetReqN) else $error("reset free without power good");
    ack_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
        mgmtAck |=> !mgmtAck) else $error("ack longer than one cycle");
    ack_cause_a: assert property (@(posedge clock) disable iff (!resetn)
        mgmtAck |-> !$past(sysMgmtInterruptN, 3) && busOutEn) else $error("ack without interrupt");
    int_latency_a: assert property (@(posedge clock) disable iff (!resetn)
        $fell(sysMgmtInterruptN) && resetReqN && powerGood |-> ##[1:8] mgmtAck) else $error("no ack");
    reset_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
        !resetReqN [*4] |-> !mgmtAck) else $error("ack during reset");
endmodule : rpseq_sva

// ---- testbench/tb_reset_powergood_sequencing.sv ----
/* testbench for board and processor ends joined by the link.
 * assumes the hdl files are compiled first. */
`timescale 1ns/1ps
module tb_reset_powergood_sequencing;
    // ****
    // signals and instances
    // ****
    localparam int POR_CYC = 20;
    localparam int RST_CYC = 200;
    logic       clock = 1'b0, resetn = 1'b0;
    logic       suppliesOk = 1'b0, clocksOk = 1'b0, warmResetReq = 1'b0;
    logic       mgmtIntReq = 1'b0, scanActive = 1'b0, execDataValid = 1'b0;
    logic [7:0] strapValue = 8'hA5, execData = 8'h00;
    logic [7:0] cfgCaptured, savedState;
    logic       inMgmtMode, outputsFloated, cacheValidAny, cpuRunning, mgmtAckSeen;
    int         error_cnt = 0, total_checks = 0, cycles = 0, n;
    always #4 clock = ~clock;
    rpseq_if u_rpseq_if (.clock(clock), .resetn(resetn));
    rpseq_board #(.POR_HOLD_CYC(POR_CYC), .RST_MAX_CYC(RST_CYC), .STABLE_CYC(4)) u_rpseq_board (
        .lnk(u_rpseq_if), .suppliesOk(suppliesOk), .clocksOk(clocksOk), .warmResetReq(warmResetReq),
        .mgmtIntReq(mgmtIntReq), .scanActive(scanActive), .strapValue(strapValue),
        .cpuRunning(cpuRunning), .mgmtAckSeen(mgmtAckSeen));
    rpseq_cpu u_rpseq_cpu (
        .lnk(u_rpseq_if), .execData(execData), .execDataValid(execDataValid), .cfgCaptured(cfgCaptured),
        .inMgmtMode(inMgmtMode), .outputsFloated(outputsFloated), .cacheValidAny(cacheValidAny),
        .savedState(savedState));
    rpseq_sva #(.POR_HOLD_CYC(POR_CYC), .RST_MAX_CYC(RST_CYC)) u_rpseq_sva (
        .clock(clock), .resetn(resetn), .powerGood(u_rpseq_if.powerGood), .resetReqN(u_rpseq_if.resetReqN),
        .sysMgmtInterruptN(u_rpseq_if.sysMgmtInterruptN), .busOutEn(u_rpseq_if.busOutEn),
        .mgmtAck(u_rpseq_if.mgmtAck));
    // ****
    // helpers
    // ****
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task wait_reset(input logic lvl);
        for (n = 0; n < 300 && u_rpseq_if.resetReqN !== lvl; n++) @(negedge clock);
    endtask : wait_reset
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // ****
    // scenarios
    // ****
    task test_power_on();
        suppliesOk = 1'b1;
        clocksOk = 1'b1;
        for (n = 0; n < 400 && cpuRunning !== 1'b1; n++) @(negedge clock);
        wait_reset(1'b1);
        repeat (6) @(negedge clock);
        check("straps", cfgCaptured, 8'hA5);
        check("float", 8'(outputsFloated), 8'h00);
        $display("test_power_on done");
    endtask : test_power_on
    task test_warm();
        int low;
        execDataValid = 1'b1;
        repeat (3) @(negedge clock);
        execDataValid = 1'b0;
        check("fill", 8'(cacheValidAny), 8'h01);
        strapValue = 8'h3C;
        warmResetReq = 1'b1;
        @(negedge clock);
        warmResetReq = 1'b0;
        wait_reset(1'b0);
        repeat (6) @(negedge clock);
        check("cache", 8'(cacheValidAny), 8'h00);
        check("busen", 8'(u_rpseq_if.busOutEn), 8'h00);
        for (low = 6; low < 300 && u_rpseq_if.resetReqN === 1'b0; low++) @(negedge clock);
        check("hold", 8'(low >= POR_CYC && low <= RST_CYC), 8'h01);
        repeat (6) @(negedge clock);
        check("straps", cfgCaptured, 8'h3C);
        $display("test_warm done");
    endtask : test_warm
    task test_mgmt();
        execData = 8'h5A;
        mgmtIntReq = 1'b1;
        for (n = 0; n < 12 && mgmtAckSeen !== 1'b1; n++) @(negedge clock);
        check("ack", 8'(n < 12), 8'h01);
        check("mode", 8'(inMgmtMode), 8'h01);
        check("saved", savedState, 8'h5A);
        check("busout", u_rpseq_if.busOut, 8'h5A);
        mgmtIntReq = 1'b0;
        repeat (4) @(negedge clock);
        $display("test_mgmt done");
    endtask : test_mgmt
    task test_float();
        warmResetReq = 1'b1;
        @(negedge clock);
        warmResetReq = 1'b0;
        wait_reset(1'b0);
        mgmtIntReq = 1'b1;
        wait_reset(1'b1);
        for (n = 0; n < 8; n++) begin
            @(negedge clock);
            check("float", 8'(outputsFloated), 8'h01);
        end
        check("release", 8'(u_rpseq_if.resetReqN), 8'h01);
        check("busout", u_rpseq_if.busOut, 8'h00);
        check("busen", 8'(u_rpseq_if.busOutEn), 8'h00);
        check("mode", 8'(inMgmtMode), 8'h00);
        mgmtIntReq = 1'b0;
        $display("test_float done");
    endtask : test_float
    task test_power_loss();
        scanActive = 1'b1;
        repeat (2) @(negedge clock);
        suppliesOk = 1'b0;
        repeat (6) @(negedge clock);
        check("scan_pg", 8'(u_rpseq_if.powerGood), 8'h01);
        scanActive = 1'b0;
        repeat (6) @(negedge clock);
        check("pg", 8'(u_rpseq_if.powerGood), 8'h00);
        check("rst", 8'(u_rpseq_if.resetReqN), 8'h00);
        check("running", 8'(cpuRunning), 8'h00);
        suppliesOk = 1'b1;
        for (n = 0; n < 400 && cpuRunning !== 1'b1; n++) @(negedge clock);
        wait_reset(1'b1);
        repeat (6) @(negedge clock);
        check("refloat", 8'(outputsFloated), 8'h00);
        check("straps", cfgCaptured, 8'h3C);
        $display("test_power_loss done");
    endtask : test_power_loss
    // ****
    // main sequence
    // ****
    initial begin
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        test_power_on();
        test_warm();
        test_mgmt();
        test_float();
        test_power_loss();
        report_and_stop();
    end
endmodule : tb_reset_powergood_sequencing
